//--- hdl/drive_monitor_display_select.sv
`timescale 1ns/1ps

module drive_monitor_display_select #(
    parameter int W = 16
) (
    input  wire logic         ref_clk,          // 50 MHz clock
    input  wire logic         srst,             // Sync reset, high
    input  wire logic         psel,             // APB select
    input  wire logic         penable,          // APB enable
    input  wire logic         pwrite,           // APB write
    input  wire logic [7:0]   paddr,            // APB byte address
    input  wire logic [31:0]  pwdata,           // APB write data
    output logic      [31:0]  prdata,           // APB read data
    output logic              pready,           // APB ready
    output logic              pslverr,          // APB error
    input  wire logic         advancedIo,       // Advanced-I/O variant
    input  wire logic         analogModeSwitch, // 1 = current mode
    input  wire logic [4:0]   inputTerminals,   // Input terminals 1..5
    input  wire logic         relayOn,          // Relay state
    input  wire logic         openCollectorOn,  // Open-collector state
    input  wire logic         powerUpEvent,     // Pulse: power applied
    input  wire logic [W-1:0] outVoltage,       // Output voltage
    input  wire logic [W-1:0] outPower,         // Output power
    input  wire logic [W-1:0] torqueVal,        // Torque
    input  wire logic [W-1:0] analogVoltIn,     // First analog input
    input  wire logic [W-1:0] analogSecondIn,   // Second analog input
    output logic      [W-1:0] userMonitorValue, // Monitor value, registered
    output logic      [2:0]   userMonitorLabel, // Monitor label, registered
    output logic      [2:0]   displaySource,    // Power-up display source
    output logic      [4:0]   displayParamIndex,// Basic parameter 0-11
    output logic              hiddenGroupOpen   // Hidden group opened
);

    typedef struct packed {
        logic [2:0]   userSel;
        logic [4:0]   ponSel;
        logic [4:0]   inStatus;
        logic [1:0]   outStatus;
        logic [W-1:0] monValue;
        logic [2:0]   monLabel;
        logic [2:0]   dispSrc;
        logic [4:0]   dispParam;
        logic         hidden;
        logic [31:0]  rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    drive_monitor_pkg::monitor_label_t muxLabel;
    logic [W-1:0]  muxValue;
    logic          wrStrobe;
    logic          rdStrobe;
    logic          addrOk;
    logic [4:0]    termMask;

    // Quantity selection and clamping live in the leaf
    monitor_mux #(
        .W (W)
    ) u_mux (
        .userSel          (state_reg.userSel),
        .advancedIo       (advancedIo),
        .analogModeSwitch (analogModeSwitch),
        .outVoltage       (outVoltage),
        .outPower         (outPower),
        .torqueVal        (torqueVal),
        .analogVoltIn     (analogVoltIn),
        .analogSecondIn   (analogSecondIn),
        .monLabel         (muxLabel),
        .monValue         (muxValue)
    );

    // Zero-wait slave: access phase completes at once
    assign wrStrobe = psel && penable && pwrite;
    assign rdStrobe = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign addrOk   = (paddr == drive_monitor_pkg::OFF_USER_MONITOR_SELECT)
                   || (paddr == drive_monitor_pkg::OFF_POWER_ON_DISPLAY_SELECT)
                   || (paddr == drive_monitor_pkg::OFF_INPUT_TERMINAL_STATUS)
                   || (paddr == drive_monitor_pkg::OFF_OUTPUT_TERMINAL_STATUS)
                   || (paddr == drive_monitor_pkg::OFF_MONITOR_VALUE)
                   || (paddr == drive_monitor_pkg::OFF_DISPLAY_STATE);
    assign pslverr  = psel && penable && !addrOk;

    // Standard variant masks terminals four and five
    assign termMask = advancedIo ? 5'h1F : 5'h07;

    // Next-state logic for every register of the block
    always_comb
    begin
        state_next = state_reg;
        // Live terminal sampling, bit 0 is terminal 1
        state_next.inStatus  = inputTerminals & termMask;
        state_next.outStatus = {openCollectorOn, relayOn};
        state_next.monValue  = muxValue;
        state_next.monLabel  = muxLabel;

        // Writes out of range are ignored to keep selectors legal
        if (wrStrobe)
        begin
            if (paddr == drive_monitor_pkg::OFF_USER_MONITOR_SELECT
                && pwdata[2:0] <= drive_monitor_pkg::USER_SEL_MAX
                && pwdata[31:3] == 29'h0)
                state_next.userSel = pwdata[2:0];
            if (paddr == drive_monitor_pkg::OFF_POWER_ON_DISPLAY_SELECT
                && pwdata[4:0] <= drive_monitor_pkg::PON_SEL_MAX
                && pwdata[31:5] == 27'h0)
                state_next.ponSel = pwdata[4:0];
        end

        // Power-up picks what the display shows first
        if (powerUpEvent)
        begin
            state_next.hidden    = 1'b0;
            state_next.dispParam = 5'h00;
            unique case (state_reg.ponSel)
                drive_monitor_pkg::PON_OUT_CURRENT:
                    state_next.dispSrc = 3'(drive_monitor_pkg::SHOW_OUT_CURRENT);
                drive_monitor_pkg::PON_MOTOR_SPEED:
                    state_next.dispSrc = 3'(drive_monitor_pkg::SHOW_MOTOR_SPEED);
                drive_monitor_pkg::PON_DC_BUS:
                    state_next.dispSrc = 3'(drive_monitor_pkg::SHOW_DC_BUS);
                drive_monitor_pkg::PON_USER_MON:
                    state_next.dispSrc = 3'(drive_monitor_pkg::SHOW_USER_MON);
                drive_monitor_pkg::PON_FAULT:
                    state_next.dispSrc = 3'(drive_monitor_pkg::SHOW_FAULT);
                drive_monitor_pkg::PON_HIDDEN:
                begin
                    state_next.dispSrc = 3'(drive_monitor_pkg::SHOW_HIDDEN);
                    state_next.hidden  = 1'b1;
                end
                default:
                begin
                    // Codes 0-11 name a basic setting parameter
                    state_next.dispSrc   = 3'(drive_monitor_pkg::SHOW_PARAM);
                    state_next.dispParam = state_reg.ponSel;
                end
            endcase
        end

        // Read data captured in setup, held through access
        if (rdStrobe)
        begin
            unique case (paddr)
                drive_monitor_pkg::OFF_USER_MONITOR_SELECT:
                    state_next.rdata = {29'h0, state_reg.userSel};
                drive_monitor_pkg::OFF_POWER_ON_DISPLAY_SELECT:
                    state_next.rdata = {27'h0, state_reg.ponSel};
                drive_monitor_pkg::OFF_INPUT_TERMINAL_STATUS:
                    state_next.rdata = {27'h0, state_reg.inStatus};
                drive_monitor_pkg::OFF_OUTPUT_TERMINAL_STATUS:
                    state_next.rdata = {30'h0, state_reg.outStatus};
                drive_monitor_pkg::OFF_MONITOR_VALUE:
                    state_next.rdata = {13'h0, state_reg.monLabel,
                                        16'(state_reg.monValue)};
                drive_monitor_pkg::OFF_DISPLAY_STATE:
                    state_next.rdata = {23'h0, state_reg.hidden,
                                        state_reg.dispParam,
                                        state_reg.dispSrc};
                default:
                    state_next.rdata = 32'h0;
            endcase
        end
    end

    // Single register stage for the whole state
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_reg           <= '0;
            state_reg.userSel   <= drive_monitor_pkg::USER_SEL_RESET;
            state_reg.ponSel    <= drive_monitor_pkg::PON_SEL_RESET;
            state_reg.outStatus <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata            = state_reg.rdata;
    assign userMonitorValue  = state_reg.monValue;
    assign userMonitorLabel  = state_reg.monLabel;
    assign displaySource     = state_reg.dispSrc;
    assign displayParamIndex = state_reg.dispParam;
    assign hiddenGroupOpen   = state_reg.hidden;

endmodule

//--- hdl/drive_monitor_pkg.sv
package drive_monitor_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFF_USER_MONITOR_SELECT     = 8'h00;
    localparam logic [7:0] OFF_POWER_ON_DISPLAY_SELECT = 8'h04;
    localparam logic [7:0] OFF_INPUT_TERMINAL_STATUS   = 8'h08;
    localparam logic [7:0] OFF_OUTPUT_TERMINAL_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_MONITOR_VALUE           = 8'h10;
    localparam logic [7:0] OFF_DISPLAY_STATE           = 8'h14;

    // Field widths
    localparam int USER_SEL_W   = 3;
    localparam int PON_SEL_W    = 5;
    localparam int IN_TERM_ADV  = 5;
    localparam int IN_TERM_STD  = 3;
    localparam int OUT_TERM_W   = 2;
    localparam int VALUE_W      = 16;

    // Reset values and ranges
    localparam logic [2:0] USER_SEL_RESET = 3'h0;
    localparam logic [2:0] USER_SEL_MAX   = 3'h4;
    localparam logic [4:0] PON_SEL_RESET  = 5'h00;
    localparam logic [4:0] PON_SEL_MAX    = 5'h11;

    // Power-on selector codes with special meaning
    localparam logic [4:0] PON_OUT_CURRENT = 5'h0C;
    localparam logic [4:0] PON_MOTOR_SPEED = 5'h0D;
    localparam logic [4:0] PON_DC_BUS      = 5'h0E;
    localparam logic [4:0] PON_USER_MON    = 5'h0F;
    localparam logic [4:0] PON_FAULT       = 5'h10;
    localparam logic [4:0] PON_HIDDEN      = 5'h11;

    // Second analog input clamps: 20 mA and 10 V in 0.01 units
    localparam int          ANALOG_MA_MAX   = 20;
    localparam int          ANALOG_V_MAX    = 10;
    localparam logic [15:0] CLAMP_CURRENT   = 16'(ANALOG_MA_MAX * 100);
    localparam logic [15:0] CLAMP_VOLTAGE   = 16'(ANALOG_V_MAX * 100);

    // Monitor labels shown for the user-select monitor
    typedef enum logic [2:0] {
        LABEL_VOLTAGE,
        LABEL_POWER,
        LABEL_TORQUE,
        LABEL_ANALOG_V,
        LABEL_ANALOG_2
    } monitor_label_t;

    // Display sources shown at power-up
    typedef enum logic [2:0] {
        SHOW_PARAM,
        SHOW_OUT_CURRENT,
        SHOW_MOTOR_SPEED,
        SHOW_DC_BUS,
        SHOW_USER_MON,
        SHOW_FAULT,
        SHOW_HIDDEN
    } display_src_t;

endpackage

//--- hdl/monitor_mux.sv
`timescale 1ns/1ps

// Picks the user-select quantity and its label; clamps the second input
module monitor_mux #(
    parameter int W = 16
) (
    input  wire logic [2:0]   userSel,        // Monitor selector
    input  wire logic         advancedIo,     // Advanced-I/O variant
    input  wire logic         analogModeSwitch, // 1 = current mode
    input  wire logic [W-1:0] outVoltage,     // Output voltage
    input  wire logic [W-1:0] outPower,       // Output power
    input  wire logic [W-1:0] torqueVal,      // Torque
    input  wire logic [W-1:0] analogVoltIn,   // First analog input
    input  wire logic [W-1:0] analogSecondIn, // Second analog input
    output drive_monitor_pkg::monitor_label_t monLabel, // Label shown
    output logic      [W-1:0] monValue        // Value shown
);

    logic [W-1:0] clampLimit;

    // Current mode tops out at 20 mA, voltage mode at 10 V
    always_comb
    begin
        clampLimit = analogModeSwitch ? W'(drive_monitor_pkg::CLAMP_CURRENT)
                                      : W'(drive_monitor_pkg::CLAMP_VOLTAGE);
        monLabel = drive_monitor_pkg::LABEL_VOLTAGE;
        monValue = outVoltage;
        unique case (userSel)
            3'h0:
            begin
                monLabel = drive_monitor_pkg::LABEL_VOLTAGE;
                monValue = outVoltage;
            end
            3'h1:
            begin
                monLabel = drive_monitor_pkg::LABEL_POWER;
                monValue = outPower;
            end
            3'h2:
            begin
                monLabel = drive_monitor_pkg::LABEL_TORQUE;
                monValue = torqueVal;
            end
            3'h3:
            begin
                monLabel = drive_monitor_pkg::LABEL_ANALOG_V;
                monValue = analogVoltIn;
            end
            3'h4:
            begin
                // Standard variant has no second input; fall back
                if (advancedIo)
                begin
                    monLabel = drive_monitor_pkg::LABEL_ANALOG_2;
                    monValue = (analogSecondIn > clampLimit) ?
                               clampLimit : analogSecondIn;
                end
            end
            default:
            begin
                monLabel = drive_monitor_pkg::LABEL_VOLTAGE;
                monValue = outVoltage;
            end
        endcase
    end

endmodule

//--- verif/drive_monitor_properties.sv
`timescale 1ns/1ps
// Port-level relations of the monitor and power-up display selector
module drive_monitor_properties #(
    parameter int W = 16
) (
    input wire logic         ref_clk,           // Clock
    input wire logic         srst,              // Reset
    input wire logic         psel,              // APB
    input wire logic         penable,           // APB
    input wire logic         pwrite,            // APB
    input wire logic [7:0]   paddr,             // APB
    input wire logic [31:0]  pwdata,            // APB
    input wire logic [31:0]  prdata,            // APB
    input wire logic         advancedIo,        // Variant
    input wire logic         analogModeSwitch,  // Mode
    input wire logic [4:0]   inputTerminals,    // Inputs
    input wire logic         relayOn,           // Relay
    input wire logic         openCollectorOn,   // Open collector
    input wire logic         powerUpEvent,      // Power-up
    input wire logic [W-1:0] outVoltage,        // Voltage
    input wire logic [W-1:0] userMonitorValue,  // Value
    input wire logic [2:0]   userMonitorLabel,  // Label
    input wire logic [2:0]   displaySource,     // Source
    input wire logic [4:0]   displayParamIndex, // Index
    input wire logic         hiddenGroupOpen    // Hidden
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Read access, and the last selector written
    logic       rdAcc;
    logic [2:0] selSeen;
    assign rdAcc = psel && penable && !pwrite;
    always_ff @(posedge ref_clk)
        if (psel && penable && pwrite && paddr == 8'h00)
            selSeen <= pwdata[2:0];

    // Label may lag one edge for the register and one for the output
    a_label_follows:
        assert property (psel && penable && pwrite && paddr == 8'h00
            && pwdata <= 32'h4 && (pwdata != 32'h4 || advancedIo)
            |-> ##[1:2] userMonitorLabel == selSeen)
        else $error("label does not follow selector");
    // The label is registered, so it answers to the variant one edge back
    a_second_variant:
        assert property (userMonitorLabel == 3'h4 |-> $past(advancedIo))
        else $error("second input shown on standard variant");
    a_second_clamp:
        assert property (!$past(srst) && userMonitorLabel == 3'h4
            |-> userMonitorValue <= ($past(analogModeSwitch) ?
            drive_monitor_pkg::CLAMP_CURRENT :
            drive_monitor_pkg::CLAMP_VOLTAGE))
        else $error("second input above its clamp");
    a_voltage_pass:
        assert property (!$past(srst) && userMonitorLabel == 3'h0
            |-> userMonitorValue == $past(outVoltage))
        else $error("voltage not passed to monitor");
    a_input_status:
        assert property (rdAcc && paddr == 8'h08 |-> prdata == {27'h0,
            $past(inputTerminals, 2)
            & ($past(advancedIo, 2) ? 5'h1F : 5'h07)})
        else $error("input status word wrong");
    a_output_status:
        assert property (rdAcc && paddr == 8'h0C |-> prdata == {30'h0,
            $past(openCollectorOn, 2), $past(relayOn, 2)})
        else $error("output status word wrong");
    a_param_only:
        assert property (displaySource != 3'h0 |-> displayParamIndex == 5'h00)
        else $error("parameter index with other source");
    a_param_range:
        assert property (displaySource == 3'h0 |-> displayParamIndex <= 5'h0B)
        else $error("parameter index above 11");
    a_source_event:
        assert property (!$stable(displaySource) |-> $past(powerUpEvent))
        else $error("display source moved without power-up");
    a_hidden_event:
        assert property ($rose(hiddenGroupOpen)
            |-> $past(powerUpEvent) && displaySource == 3'h6)
        else $error("hidden group opened wrongly");

    c_second: cover property (userMonitorLabel == 3'h4);
    c_hidden: cover property (hiddenGroupOpen);
    c_both_out: cover property (rdAcc && paddr == 8'h0C && prdata[1:0] == 2'h3);
endmodule

//--- verif/test_drive_monitor_display_select.sv
`timescale 1ns/1ps
// Drives registers over APB and the terminal and measurement inputs
module test_drive_monitor_display_select;
    localparam int         W = 16;
    localparam logic [7:0] SEL_A = drive_monitor_pkg::OFF_USER_MONITOR_SELECT;
    localparam logic [7:0] PON_A = drive_monitor_pkg::OFF_POWER_ON_DISPLAY_SELECT;
    localparam logic [7:0] IN_A  = drive_monitor_pkg::OFF_INPUT_TERMINAL_STATUS;
    localparam logic [7:0] OUT_A = drive_monitor_pkg::OFF_OUTPUT_TERMINAL_STATUS;
    localparam logic [7:0] MON_A = drive_monitor_pkg::OFF_MONITOR_VALUE;
    localparam logic [7:0] DSP_A = drive_monitor_pkg::OFF_DISPLAY_STATE;
    logic         ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic         pwrite = 1'b0, pready, pslverr, hiddenGroupOpen;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata;
    logic         advancedIo = 1'b1, analogModeSwitch = 1'b0, relayOn = 1'b0;
    logic         openCollectorOn = 1'b0, powerUpEvent = 1'b0;
    logic [4:0]   inputTerminals = 5'h00, displayParamIndex, tIn;
    logic [W-1:0] outVoltage = 16'h0, outPower = 16'h0, torqueVal = 16'h0;
    logic [W-1:0] analogVoltIn = 16'h0, analogSecondIn = 16'h0;
    logic [W-1:0] userMonitorValue, val, lim;
    logic [2:0]   userMonitorLabel, displaySource, sel, src;
    logic [32:0]  expQ[$];
    int           errTotal = 0, testsRun = 0, cycles = 0;

    drive_monitor_display_select #(.W(W)) DUT (
        .ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .advancedIo, .analogModeSwitch, .inputTerminals,
        .relayOn, .openCollectorOn, .powerUpEvent, .outVoltage, .outPower,
        .torqueVal, .analogVoltIn, .analogSecondIn, .userMonitorValue,
        .userMonitorLabel, .displaySource, .displayParamIndex, .hiddenGroupOpen
    );

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        testsRun++;
        if (seen !== want)
        begin
            errTotal++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d, wrong %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected {pslverr, prdata} is noted before the read starts
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse_power();
        @(posedge ref_clk);
        powerUpEvent <= 1'b1;
        @(posedge ref_clk);
        powerUpEvent <= 1'b0;
    endtask

    // Each completed read takes the oldest note
    always @(posedge ref_clk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, expQ.pop_front());

    // Hang guard; the run needs under 1000 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errTotal++;
            report_and_stop();
        end
    end

    initial
    begin
        void'($urandom(32'hC973));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        rd(SEL_A, 33'h0);
        rd(PON_A, 33'h0);
        rd(OUT_A, 33'h0);
        pulse_power();
        rd(DSP_A, 33'h0);
        $display("test reset done");
        // Every selector in both analog modes, clamp hit at random
        for (int m = 0; m < 20; m++)
        begin
            sel = 3'(m % 5);
            @(posedge ref_clk);
            analogModeSwitch <= 1'((m / 5) % 2);
            {outVoltage, outPower} <= $urandom;
            {torqueVal, analogVoltIn} <= $urandom;
            analogSecondIn <= 16'($urandom_range(3000));
            apb(1'b1, SEL_A, {29'h0, sel});
            lim = analogModeSwitch ? drive_monitor_pkg::CLAMP_CURRENT
                                   : drive_monitor_pkg::CLAMP_VOLTAGE;
            case (sel)
                3'h0: val = outVoltage;
                3'h1: val = outPower;
                3'h2: val = torqueVal;
                3'h3: val = analogVoltIn;
                default: val = analogSecondIn > lim ? lim : analogSecondIn;
            endcase
            rd(MON_A, {14'h0, sel, val});
        end
        $display("test monitor done");
        // Refused values keep the old one; an unmapped place errs
        apb(1'b1, SEL_A, 32'h5);
        apb(1'b1, SEL_A, 32'h101);
        rd(SEL_A, 33'h4);
        apb(1'b1, 8'h18, 32'h1);
        rd(8'h18, 33'h1_0000_0000);
        // Standard variant hides the second input and terminals 4 and 5
        @(posedge ref_clk);
        advancedIo <= 1'b0;
        apb(1'b1, SEL_A, 32'h4);
        rd(MON_A, {17'h0, outVoltage});
        for (int k = 0; k < 4; k++)
        begin
            tIn = 5'($urandom);
            @(posedge ref_clk);
            inputTerminals <= tIn;
            {openCollectorOn, relayOn} <= 2'(k);
            rd(IN_A, {28'h0, tIn & 5'h07});
            rd(OUT_A, {31'h0, 2'(k)});
        end
        @(posedge ref_clk);
        advancedIo <= 1'b1;
        rd(IN_A, {28'h0, tIn});
        $display("test status done");
        // Every power-up code, then one refused code
        for (int p = 0; p < 19; p++)
        begin
            apb(1'b1, PON_A, 32'(p));
            pulse_power();
            src = p < 12 ? 3'h0 : p > 17 ? 3'h6 : 3'(p - 11);
            rd(DSP_A, {24'h0, p >= 17, p < 12 ? 5'(p) : 5'h00, src});
        end
        rd(PON_A, 33'h11);
        $display("test power-up done");
        @(posedge ref_clk);
        report_and_stop();
    end
endmodule

bind drive_monitor_display_select drive_monitor_properties #(.W(W)) chk (
    .ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .advancedIo, .analogModeSwitch, .inputTerminals, .relayOn,
    .openCollectorOn, .powerUpEvent, .outVoltage, .userMonitorValue,
    .userMonitorLabel, .displaySource, .displayParamIndex, .hiddenGroupOpen
);
